// >>> design/dcu_core.sv
// Function
// R1 - two channels, each sends and receives concurrently
// R2 - transmit queue eight bytes deep
// R3 - receive queue sixteen entries, data plus status
// R4 - seven or eight data bits, one/two stops
// R5 - optional parity, even or odd
// R6 - exactly one start bit per frame
// R7 - receiver deserializes into receive queue
// R8 - transmit queue bytes serialized onto line
// R9 - oversample clock is sixteen times baud
// R10 - oversample source: bus, external pin, generator
// R11 - generator divides by prescale times divisor times sixteen
// R12 - prescale 2/8/32/128, divisor 1 to 255
// R13 - external clock at most 45% bus clock
// R14 - recovers characters within 3.12% rate error
// R15 - clear-to-send and request-to-send flow control
// R16 - DMA requests fill transmit, empty receive
// R17 - master or slave role on shared line
// R18 - start only on falling receive edge
// R19 - level flag when count exceeds trigger level
// R20 - data bits least significant first
`timescale 1ns/1ns
`default_nettype none
module dcu_core
	import dcu_pkg::*;
(
	input  wire logic                          clock,                 // 100 MHz bus clock
	input  wire logic                          sys_rst,               // sync reset, high
	input  wire logic                          ext_clk,               // external clock pin
	input  wire logic [DCU_CH-1:0][7:0]        tx_data,               // byte to send
	input  wire logic [DCU_CH-1:0]             tx_valid,              // byte offered
	output logic      [DCU_CH-1:0]             tx_ready,              // transmit queue room
	output logic      [DCU_CH-1:0][7:0]        rx_data,               // received byte
	output logic      [DCU_CH-1:0][4:0]        rx_status,             // status of that byte
	output logic      [DCU_CH-1:0]             rx_valid,              // entry available
	input  wire logic [DCU_CH-1:0]             rx_ready,              // entry taken
	input  wire logic [DCU_CH-1:0]             seven_bit,             // seven data bits
	input  wire logic [DCU_CH-1:0]             two_stop,              // two stop bits
	input  wire logic [DCU_CH-1:0]             parity_en,             // parity bit present
	input  wire logic [DCU_CH-1:0]             parity_odd,            // odd parity
	input  wire logic [DCU_CH-1:0][1:0]        clk_sel,               // oversample source
	input  wire logic [DCU_CH-1:0]             brg_src_ext,           // generator from pin
	input  wire logic [DCU_CH-1:0][1:0]        prescale_sel,          // 2,8,32,128
	input  wire logic [DCU_CH-1:0][7:0]        divisor,               // 1..255
	input  wire logic [DCU_CH-1:0]             receive_disable_bit,   // receiver off
	input  wire logic [DCU_CH-1:0]             flow_en,               // cts/rts in use
	input  wire logic [DCU_CH-1:0]             slave_mode,            // drive line only in frame
	input  wire logic [DCU_CH-1:0][3:0]        receive_trigger_level, // level flag threshold
	input  wire logic [DCU_CH-1:0]             rxd,                   // receive pin
	input  wire logic [DCU_CH-1:0]             cts_n,                 // clear to send, low
	output logic      [DCU_CH-1:0]             txd_o,                 // transmit pin level
	output logic      [DCU_CH-1:0]             txd_oe,                // transmit pin enable
	output logic      [DCU_CH-1:0]             rts_n,                 // request to send, low
	output logic      [DCU_CH-1:0]             receive_level_flag,    // queue above trigger
	output logic      [DCU_CH-1:0]             dma_tx_req,            // dma may fill
	output logic      [DCU_CH-1:0]             dma_rx_req             // dma should empty
);
	dcu_top_s                  st_reg;
	dcu_top_s                  st_next;
	logic [DCU_CH-1:0]         tx_pop;
	logic [DCU_CH-1:0][7:0]    txq_data;
	logic [DCU_CH-1:0]         txq_valid;
	logic [DCU_CH-1:0][TXQ_CW-1:0] txq_count;
	logic [DCU_CH-1:0]         rxq_ready;
	logic [DCU_CH-1:0][RXQ_W-1:0]  rxq_data;
	logic [DCU_CH-1:0][RXQ_CW-1:0] rxq_count;
	logic [DCU_CH-1:0]         os_tick;

	////////////////////////////////////////////////////////////////////////
	// per-channel queues
	generate
		for (genvar g = 0; g < DCU_CH; g++) begin : g_q
			dcu_fifo #(.WIDTH(TXQ_W), .DEPTH(TXQ_D), .CW(TXQ_CW)) u_txq ( // see R2
				.clock     (clock),
				.sys_rst   (sys_rst),
				.in_data   (tx_data[g]),
				.in_valid  (tx_valid[g]),
				.in_ready  (tx_ready[g]),
				.out_data  (txq_data[g]),
				.out_valid (txq_valid[g]),
				.out_ready (tx_pop[g]),
				.count     (txq_count[g])
			);
			dcu_fifo #(.WIDTH(RXQ_W), .DEPTH(RXQ_D), .CW(RXQ_CW)) u_rxq ( // see R3
				.clock     (clock),
				.sys_rst   (sys_rst),
				.in_data   (st_reg.ch[g].push_data),
				.in_valid  (st_reg.ch[g].push_valid),
				.in_ready  (rxq_ready[g]),
				.out_data  (rxq_data[g]),
				.out_valid (rx_valid[g]),
				.out_ready (rx_ready[g]),
				.count     (rxq_count[g])
			);
			assign rx_data[g]   = rxq_data[g][7:0];
			assign rx_status[g] = rxq_data[g][12:8];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// channel engines; both channels share only the external clock pin
	always_comb begin
		logic        ext_edge;
		logic        src_tick;
		logic        brg_tick;
		logic [2:0]  last;
		logic [7:0]  rbyte;
		dcu_ch_s     c;
		dcu_ch_s     n;
		ext_edge = 1'b0;
		src_tick = 1'b0;
		brg_tick = 1'b0;
		last     = 3'h0;
		rbyte    = 8'h00;
		c        = '0;
		n        = '0;
		st_next  = st_reg;
		tx_pop   = '0;
		os_tick  = '0;
		st_next.ext_meta = ext_clk;
		st_next.ext_sync = st_reg.ext_meta;
		st_next.ext_prev = st_reg.ext_sync;
		// pin rate is bounded, so one synced edge is one pin cycle
		ext_edge = st_reg.ext_sync && !st_reg.ext_prev; // see R13
		for (int i = 0; i < DCU_CH; i++) begin // see R1
			c = st_reg.ch[i];
			n = c;
			n.rx_meta    = rxd[i];
			n.rx_sync    = c.rx_meta;
			n.rx_prev    = c.rx_sync;
			n.cts_meta   = cts_n[i];
			n.cts_sync   = c.cts_meta;
			n.push_valid = 1'b0;
			// rate generator: one tick per prescale times divisor source clocks
			src_tick = brg_src_ext[i] ? ext_edge : 1'b1;
			brg_tick = src_tick && (c.brg_cnt == 15'h0000);
			if (src_tick) begin
				n.brg_cnt = brg_tick ? dcu_brg_limit(divisor[i], prescale_sel[i]) // see R11 R12
				                     : c.brg_cnt - 15'h0001;
			end
			case (clk_sel[i]) // see R10
				CLK_BUS: os_tick[i] = 1'b1;
				CLK_EXT: os_tick[i] = ext_edge;
				CLK_BRG: os_tick[i] = brg_tick;
				default: os_tick[i] = 1'b0;
			endcase
			last = seven_bit[i] ? BIT_LAST7 : BIT_LAST8; // see R4

			// transmitter
			if (os_tick[i] && c.tx_st != TX_IDLE) begin
				n.tx_tick = c.tx_tick + 4'h1; // see R9
			end
			case (c.tx_st)
				TX_IDLE: begin
					n.txd = 1'b1;
					if (txq_valid[i] && !(flow_en[i] && c.cts_sync)) begin // see R15
						tx_pop[i]  = 1'b1; // see R8
						n.tx_st    = TX_START;
						n.tx_shift = txq_data[i];
						n.tx_par   = 1'b0;
						n.tx_tick  = 4'h0;
						n.txd      = 1'b0; // see R6
					end
				end
				TX_START: begin
					if (os_tick[i] && c.tx_tick == OS_LAST) begin
						n.tx_st  = TX_DATA;
						n.tx_bit = 3'h0;
						n.txd    = c.tx_shift[0]; // see R20
					end
				end
				TX_DATA: begin
					if (os_tick[i] && c.tx_tick == OS_LAST) begin
						n.tx_par   = c.tx_par ^ c.tx_shift[0];
						n.tx_shift = {1'b0, c.tx_shift[7:1]};
						n.tx_bit   = c.tx_bit + 3'h1;
						n.txd      = c.tx_shift[1];
						if (c.tx_bit == last) begin
							n.tx_stop2 = two_stop[i];
							n.tx_st    = parity_en[i] ? TX_PAR : TX_STOP;
							n.txd      = parity_en[i] ? (c.tx_par ^ c.tx_shift[0] ^ parity_odd[i]) // see R5
							                          : 1'b1;
						end
					end
				end
				TX_PAR: begin
					if (os_tick[i] && c.tx_tick == OS_LAST) begin
						n.tx_st = TX_STOP;
						n.txd   = 1'b1;
					end
				end
				TX_STOP: begin
					if (os_tick[i] && c.tx_tick == OS_LAST) begin
						n.tx_stop2 = 1'b0;
						n.tx_st    = c.tx_stop2 ? TX_STOP : TX_IDLE; // see R4
					end
				end
				default: n.tx_st = TX_IDLE;
			endcase
			// a slave leaves the shared line to the pull-up between frames
			n.txd_oe = !slave_mode[i] || n.tx_st != TX_IDLE; // see R17

			// receiver; sampling at mid-bit gives the margin for rate error
			if (os_tick[i] && c.rx_st != RX_IDLE) begin
				n.rx_tick = c.rx_tick + 4'h1;
			end
			case (c.rx_st)
				RX_IDLE: begin
					if (c.rx_prev && !c.rx_sync) begin // see R18
						n.rx_st   = RX_START;
						n.rx_tick = 4'h0;
					end
				end
				RX_START: begin
					if (os_tick[i] && c.rx_tick == OS_MID) begin // see R14
						n.rx_st   = c.rx_sync ? RX_IDLE : RX_DATA;
						n.rx_tick = 4'h0;
						n.rx_bit  = 3'h0;
						n.rx_par  = 1'b0;
					end
				end
				RX_DATA: begin
					if (os_tick[i] && c.rx_tick == OS_LAST) begin
						n.rx_shift = {c.rx_sync, c.rx_shift[7:1]}; // see R20 R7
						n.rx_par   = c.rx_par ^ c.rx_sync;
						n.rx_bit   = c.rx_bit + 3'h1;
						n.rx_perr  = 1'b0;
						if (c.rx_bit == last) begin
							n.rx_st = parity_en[i] ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (os_tick[i] && c.rx_tick == OS_LAST) begin
						n.rx_perr = c.rx_par ^ c.rx_sync ^ parity_odd[i]; // see R5
						n.rx_st   = RX_STOP;
					end
				end
				RX_STOP: begin
					// only the first stop bit is checked
					if (os_tick[i] && c.rx_tick == OS_LAST) begin
						rbyte        = seven_bit[i] ? {1'b0, c.rx_shift[7:1]} : c.rx_shift;
						n.push_valid = 1'b1;
						n.push_data  = {seven_bit[i], c.rx_ovr, !c.rx_sync && rbyte == 8'h00,
						                !c.rx_sync, c.rx_perr, rbyte}; // see R3
						n.rx_st      = RX_IDLE;
					end
				end
				default: n.rx_st = RX_IDLE;
			endcase
			if (receive_disable_bit[i]) begin
				n.rx_st = RX_IDLE;
			end
			// a dropped byte marks the next stored one
			if (c.push_valid) begin
				n.rx_ovr = !rxq_ready[i];
			end

			n.rts_n      = flow_en[i] && (rxq_count[i] >= RTS_LEVEL); // see R15
			n.level_flag = rxq_count[i] > {1'b0, receive_trigger_level[i]}; // see R19
			n.dma_tx_req = txq_count[i] != TXQ_CW'(TXQ_D); // see R16
			st_next.ch[i] = n;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg          <= '0;
			st_reg.ch[0]    <= dcu_ch_reset();
			st_reg.ch[1]    <= dcu_ch_reset();
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin and flag outputs, all straight from the state register
	generate
		for (genvar g = 0; g < DCU_CH; g++) begin : g_out
			assign txd_o[g]              = st_reg.ch[g].txd;
			assign txd_oe[g]             = st_reg.ch[g].txd_oe;
			assign rts_n[g]              = st_reg.ch[g].rts_n;
			assign receive_level_flag[g] = st_reg.ch[g].level_flag;
			assign dma_rx_req[g]         = st_reg.ch[g].level_flag; // see R16
			assign dma_tx_req[g]         = st_reg.ch[g].dma_tx_req;

			////////////////////////////////////////////////////////////////
			// checks on the engines of this channel
			sequence s_leave_idle;
				st_reg.ch[g].tx_st == TX_IDLE ##1 st_reg.ch[g].tx_st == TX_START;
			endsequence
			property p_start_low;
				@(posedge clock) disable iff (sys_rst)
				s_leave_idle |-> !st_reg.ch[g].txd;
			endproperty
			a_start_low: assert property (p_start_low) else $error("start bit not low"); // see R6
			property p_pop_start;
				@(posedge clock) disable iff (sys_rst)
				tx_pop[g] |=> st_reg.ch[g].tx_st == TX_START && st_reg.ch[g].tx_shift == $past(txq_data[g]);
			endproperty
			a_pop_start: assert property (p_pop_start) else $error("popped byte not sent"); // see R8
			property p_stop_high;
				@(posedge clock) disable iff (sys_rst)
				st_reg.ch[g].tx_st == TX_STOP |-> st_reg.ch[g].txd;
			endproperty
			a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // see R4
			property p_par_bit;
				@(posedge clock) disable iff (sys_rst)
				$rose(st_reg.ch[g].tx_st == TX_PAR) |->
					st_reg.ch[g].txd == (st_reg.ch[g].tx_par ^ $past(parity_odd[g]));
			endproperty
			a_par_bit: assert property (p_par_bit) else $error("wrong parity bit"); // see R5
			property p_bus_rate;
				@(posedge clock) disable iff (sys_rst)
				clk_sel[g] == CLK_BUS && st_reg.ch[g].tx_st == TX_DATA && st_next.ch[g].tx_st == TX_DATA
				|=> st_reg.ch[g].tx_tick == $past(st_reg.ch[g].tx_tick) + 4'h1;
			endproperty
			a_bus_rate: assert property (p_bus_rate) else $error("tick not every cycle"); // see R9 R10
			property p_brg_reload;
				@(posedge clock) disable iff (sys_rst)
				!sys_rst && !brg_src_ext[g] && st_reg.ch[g].brg_cnt == 15'h0000 |=>
					st_reg.ch[g].brg_cnt == dcu_brg_limit($past(divisor[g]), $past(prescale_sel[g]));
			endproperty
			a_brg_reload: assert property (p_brg_reload) else $error("bad generator reload"); // see R11 R12
			property p_level;
				@(posedge clock) disable iff (sys_rst)
				rxq_count[g] > {1'b0, receive_trigger_level[g]} |=> receive_level_flag[g] && dma_rx_req[g];
			endproperty
			a_level: assert property (p_level) else $error("level flag missing"); // see R19
			property p_no_low_start;
				@(posedge clock) disable iff (sys_rst)
				st_reg.ch[g].rx_st == RX_IDLE && !st_reg.ch[g].rx_prev |=> st_reg.ch[g].rx_st == RX_IDLE;
			endproperty
			a_no_low_start: assert property (p_no_low_start) else $error("start without edge"); // see R18
			property p_cts_hold;
				@(posedge clock) disable iff (sys_rst)
				flow_en[g] && st_reg.ch[g].cts_sync |-> !tx_pop[g];
			endproperty
			a_cts_hold: assert property (p_cts_hold) else $error("sent while cts high"); // see R15
			property p_false_start;
				@(posedge clock) disable iff (sys_rst)
				st_reg.ch[g].rx_st == RX_START && os_tick[g] && st_reg.ch[g].rx_tick == OS_MID
				&& st_reg.ch[g].rx_sync |=> st_reg.ch[g].rx_st == RX_IDLE;
			endproperty
			a_false_start: assert property (p_false_start) else $error("glitch taken as start"); // see R14
		end
	endgenerate
endmodule // dcu_core
`default_nettype wire

// >>> design/dcu_pkg.sv
package dcu_pkg;
	localparam int DCU_CH = 2;
	localparam int TXQ_W  = 8;
	localparam int TXQ_D  = 8;
	localparam int TXQ_CW = 4;
	localparam int RXQ_W  = 13;
	localparam int RXQ_D  = 16;
	localparam int RXQ_CW = 5;
	// oversample phase counts, sixteen ticks a bit
	localparam logic [3:0] OS_LAST   = 4'hf;
	localparam logic [3:0] OS_MID    = 4'h7;
	localparam logic [2:0] BIT_LAST8 = 3'h7;
	localparam logic [2:0] BIT_LAST7 = 3'h6;
	localparam logic [4:0] RTS_LEVEL = 5'h0e;
	// oversample clock source codes
	localparam logic [1:0] CLK_BUS = 2'h0;
	localparam logic [1:0] CLK_EXT = 2'h1;
	localparam logic [1:0] CLK_BRG = 2'h2;
	// receive status bit positions
	localparam int ST_PERR  = 0;
	localparam int ST_FERR  = 1;
	localparam int ST_BRK   = 2;
	localparam int ST_OVR   = 3;
	localparam int ST_SEVEN = 4;
	localparam logic [14:0] BRG_RESET = 15'h0000;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
	} dcu_tx_e;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
	} dcu_rx_e;

	typedef struct packed {
		logic        rx_meta;
		logic        rx_sync;
		logic        rx_prev;
		logic        cts_meta;
		logic        cts_sync;
		logic [14:0] brg_cnt;
		dcu_tx_e     tx_st;
		logic [3:0]  tx_tick;
		logic [2:0]  tx_bit;
		logic [7:0]  tx_shift;
		logic        tx_par;
		logic        tx_stop2;
		logic        txd;
		logic        txd_oe;
		logic        rts_n;
		dcu_rx_e     rx_st;
		logic [3:0]  rx_tick;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_shift;
		logic        rx_par;
		logic        rx_perr;
		logic        rx_ovr;
		logic        push_valid;
		logic [12:0] push_data;
		logic        level_flag;
		logic        dma_tx_req;
	} dcu_ch_s;

	typedef struct packed {
		logic                     ext_meta;
		logic                     ext_sync;
		logic                     ext_prev;
		dcu_ch_s [DCU_CH-1:0]     ch;
	} dcu_top_s;

	// idle line high, handshake released, machines idle
	function automatic dcu_ch_s dcu_ch_reset();
		dcu_ch_s r;
		r          = '0;
		r.brg_cnt  = BRG_RESET;
		r.tx_st    = TX_IDLE;
		r.rx_st    = RX_IDLE;
		r.txd      = 1'b1;
		r.rts_n    = 1'b1;
		r.rx_meta  = 1'b1; // first stage idles high too, no false edge after reset
		r.rx_sync  = 1'b1;
		r.cts_meta = 1'b1;
		r.rx_prev  = 1'b1;
		r.cts_sync = 1'b1;
		return r;
	endfunction

	// prescale code 0..3 selects 2, 8, 32, 128 as a shift
	function automatic logic [2:0] dcu_pre_shift(input logic [1:0] sel);
		return {sel, 1'b1};
	endfunction

	// reload value of the rate counter; divisor 0 acts as 1
	function automatic logic [14:0] dcu_brg_limit(input logic [7:0] div, input logic [1:0] sel);
		logic [14:0] d;
		d = {7'h00, (div == 8'h00) ? 8'h01 : div};
		return (d << dcu_pre_shift(sel)) - 15'h0001;
	endfunction
endpackage

// >>> design/dcu_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module dcu_fifo
	import dcu_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int CW    = 4
) (
	input  wire logic             clock,     // system clock
	input  wire logic             sys_rst,   // sync reset
	input  wire logic [WIDTH-1:0] in_data,   // word to store
	input  wire logic             in_valid,  // word offered
	output logic                  in_ready,  // room left
	output logic      [WIDTH-1:0] out_data,  // oldest word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // word taken
	output logic      [CW-1:0]    count      // words held
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [CW-1:0]               cnt;
		logic [WIDTH-1:0]            q;
		logic                        vld;
		logic                        rdy;
	} dcu_fifo_s;
	dcu_fifo_s st_reg;
	dcu_fifo_s st_next;

	////////////////////////////////////////////////////////////////////////
	// flags and head word derive from next state so all outputs are flops
	always_comb begin
		st_next = st_reg;
		if (in_valid && st_reg.rdy) begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr             = st_reg.wr + 1'b1;
		end
		if (out_ready && st_reg.vld) begin
			st_next.rd = st_reg.rd + 1'b1;
		end
		case ({in_valid && st_reg.rdy, out_ready && st_reg.vld})
			2'b10:   st_next.cnt = st_reg.cnt + 1'b1;
			2'b01:   st_next.cnt = st_reg.cnt - 1'b1;
			default: st_next.cnt = st_reg.cnt;
		endcase
		st_next.q   = st_next.mem[st_next.rd];
		st_next.vld = st_next.cnt != '0;
		st_next.rdy = st_next.cnt != CW'(DEPTH); // honest full, stalls the writer
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg     <= '0;
			st_reg.rdy <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign in_ready  = st_reg.rdy;
	assign out_data  = st_reg.q;
	assign out_valid = st_reg.vld;
	assign count     = st_reg.cnt;
endmodule // dcu_fifo
`default_nettype wire

// >>> tb/dcu_remote.sv
`timescale 1ns/1ns
`default_nettype none
// remote serial end: line idles high, data lsb first
module dcu_remote (
	input  wire logic        clock,   // bench clock
	input  wire logic        line_in, // device transmit line
	input  wire logic        rts_n,   // device request to send
	input  wire logic [11:0] bit_cyc, // clocks per bit
	output logic             rxd,     // device receive line
	output logic             cts_n    // clear to send
);
	logic rude; // ignores rts_n when a test asks
	// idle at time zero
	initial begin
		rxd   = 1'b1;
		cts_n = 1'b0;
		rude  = 1'b0;
	end
	////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// low pins the receive line, the stuck-line hazard
	task automatic set(input logic cts, input logic r, input logic low);
		cts_n <= cts;
		rude  <= r;
		rxd   <= ~low;
	endtask
	// one frame; bad spoils the parity bit
	task automatic send(input logic [7:0] d, input logic sev, input logic pe, input logic odd, input logic bad);
		while (rts_n === 1'b1 && !rude)
			@(posedge clock);
		rxd <= 1'b0;
		wt(bit_cyc);
		for (int i = 0; i < (sev ? 7 : 8); i++) begin
			rxd <= d[i];
			wt(bit_cyc);
		end
		if (pe) begin
			rxd <= ^(d & {~sev, 7'h7f}) ^ odd ^ bad;
			wt(bit_cyc);
		end
		rxd <= 1'b1;
		wt(bit_cyc);
	endtask
	// samples mid-bit; s ands every stop bit
	task automatic get(input logic sev, input logic pe, input logic two, output logic [7:0] d, output logic p,
	                   output logic s);
		d = 8'h00;
		p = 1'b0;
		@(negedge line_in);
		wt(bit_cyc / 2);
		for (int i = 0; i < (sev ? 7 : 8); i++) begin
			wt(bit_cyc);
			d[i] = line_in;
		end
		if (pe) begin
			wt(bit_cyc);
			p = line_in;
		end
		wt(bit_cyc);
		s = line_in;
		if (two) begin
			wt(bit_cyc);
			s = s & line_in;
		end
	endtask
endmodule // dcu_remote
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import dcu_pkg::*;
();
	logic             clock, sys_rst, ext_clk, p, s;
	logic [7:0]       d, e;
	logic [1:0][7:0]  tx_data, rx_data, divisor;
	logic [1:0][4:0]  rx_status;
	logic [1:0][3:0]  receive_trigger_level;
	logic [1:0][1:0]  clk_sel, prescale_sel;
	logic [1:0][11:0] bitc;
	logic [1:0]       tx_valid, tx_ready, rx_valid, rx_ready, seven_bit, two_stop, parity_en, parity_odd, flow_en;
	logic [1:0]       brg_src_ext, receive_disable_bit, slave_mode, txd_o, txd_oe, rts_n, receive_level_flag;
	logic [1:0]       dma_tx_req, dma_rx_req;
	wire logic [1:0]  rxd, cts_n, line_lvl;
	int               n_mismatch, n_tests, cyc;
	// seven bits, parity, odd, two stops
	logic [3:0]       fmt [4] = '{4'h4, 4'h7, 4'h9, 4'he};
	// source, generator from pin, prescale, divisor, clocks per bit
	logic [24:0]      rate [6] = '{{2'h1, 1'b0, 2'h0, 8'h01, 12'h030}, {2'h2, 1'b0, 2'h0, 8'h03, 12'h060},
		{2'h2, 1'b0, 2'h1, 8'h01, 12'h080}, {2'h2, 1'b0, 2'h2, 8'h01, 12'h200}, {2'h2, 1'b0, 2'h3, 8'h01, 12'h800},
		{2'h2, 1'b1, 2'h0, 8'h01, 12'h060}};
	////////////////////////////////////////
	// released line is pulled up, so idle reads high
	assign line_lvl = txd_o | ~txd_oe;
	// pin clock at a third of the bus rate, below the 45% ceiling
	always #5 clock = ~clock;
	always #15 ext_clk <= ~ext_clk;
	dcu_core u_dut (
		.clock, .sys_rst, .ext_clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_status, .rx_valid, .rx_ready,
		.seven_bit, .two_stop, .parity_en, .parity_odd, .clk_sel, .brg_src_ext, .prescale_sel, .divisor,
		.receive_disable_bit, .flow_en, .slave_mode, .receive_trigger_level, .rxd, .cts_n, .txd_o, .txd_oe,
		.rts_n, .receive_level_flag, .dma_tx_req, .dma_rx_req
	);
	dcu_remote u_rem0 (.clock, .line_in(line_lvl[0]), .rts_n(rts_n[0]), .bit_cyc(bitc[0]), .rxd(rxd[0]),
		.cts_n(cts_n[0]));
	dcu_remote u_rem1 (.clock, .line_in(line_lvl[1]), .rts_n(rts_n[1]), .bit_cyc(bitc[1]), .rxd(rxd[1]),
		.cts_n(cts_n[1]));
	// ceiling well above the slowest rate test
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 32'h0000_ea60) begin
			n_mismatch++;
			$display("CHECK FAILED %0t timeout", $time);
			finish_test();
		end
	end
	////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// every comparison counted, a miss reported at once
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({7'h00, got}, {7'h00, exp});
	endtask
	// valid stays up so back-to-back pushes never double-drive it
	task automatic push(input int g, input logic [7:0] v);
		int w;
		w = 0;
		tx_valid[g] <= 1'b1;
		tx_data[g]  <= v;
		do begin
			@(posedge clock);
			w++;
		end while (tx_ready[g] !== 1'b1 && w < 64);
		chk_bit(tx_ready[g], 1'b1);
	endtask
	// wait for an entry, compare, take it
	task automatic pop(input int g, input logic [7:0] ed, input logic [4:0] es);
		int w;
		w = 0;
		do begin
			@(posedge clock);
			w++;
		end while (rx_valid[g] !== 1'b1 && w < 64);
		chk_bit(rx_valid[g], 1'b1);
		chk_val(rx_data[g], ed);
		chk_val({3'h0, rx_status[g]}, {3'h0, es});
		rx_ready[g] <= 1'b1;
		@(posedge clock);
		rx_ready[g] <= 1'b0;
	endtask
	////////////////////////////////////////
	initial begin
		clock = 1'b0;
		ext_clk = 1'b0;
		sys_rst = 1'b1;
		{tx_data, tx_valid, rx_ready, seven_bit, two_stop, parity_en, parity_odd, clk_sel} = '0;
		{brg_src_ext, prescale_sel, receive_disable_bit, flow_en, slave_mode} = '0;
		divisor = 16'h0101;
		receive_trigger_level = 8'hff;
		bitc = {12'h010, 12'h010};
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		chk_bit(line_lvl[0], 1'b1);
		chk_bit(dma_tx_req[0], 1'b1);
		// both directions of one channel at once
		fork
			u_rem0.send(8'hc5, 1'b0, 1'b0, 1'b0, 1'b0);
			begin
				push(0, 8'h3a);
				tx_valid[0] <= 1'b0;
				u_rem0.get(1'b0, 1'b0, 1'b0, d, p, s);
			end
		join
		chk_val(d, 8'h3a);
		chk_bit(s, 1'b1);
		pop(0, 8'hc5, 5'h00);
		$display("duplex test done");
		// four formats, two bytes out back to back, good and spoiled parity in
		slave_mode[1] <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			{seven_bit[1], parity_en[1], parity_odd[1], two_stop[1]} <= fmt[i];
			e = fmt[i][3] ? 8'h33 : 8'hb3;
			@(posedge clock);
			push(1, 8'hb3);
			push(1, 8'h4d);
			tx_valid[1] <= 1'b0;
			fork
				u_rem1.get(fmt[i][3], fmt[i][2], fmt[i][0], d, p, s);
				begin
					repeat (40) @(posedge clock);
					chk_bit(txd_oe[1], 1'b1);
				end
			join
			chk_val(d, e);
			chk_bit(p, fmt[i][2] & (^e ^ fmt[i][1]));
			chk_bit(s, 1'b1);
			u_rem1.get(fmt[i][3], fmt[i][2], fmt[i][0], d, p, s);
			chk_val(d, 8'h4d);
			for (int b = 0; b < 2; b++) begin
				u_rem1.send(8'hb3, fmt[i][3], fmt[i][2], fmt[i][1], b[0]);
				pop(1, e, {fmt[i][3], 3'h0, b[0] & fmt[i][2]});
			end
		end
		repeat (40) @(posedge clock);
		chk_bit(txd_oe[1], 1'b0);
		{seven_bit[1], parity_en[1], parity_odd[1], two_stop[1], slave_mode[1]} <= '0;
		$display("format test done");
		// line already low when the receiver is enabled
		receive_disable_bit[0] <= 1'b1;
		u_rem0.set(1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clock);
		receive_disable_bit[0] <= 1'b0;
		repeat (320) @(posedge clock);
		u_rem0.set(1'b0, 1'b0, 1'b0);
		repeat (320) @(posedge clock);
		chk_bit(rx_valid[0], 1'b0);
		// line held low past a frame reads as a break: framing error, zero data
		u_rem0.set(1'b0, 1'b0, 1'b1);
		repeat (200) @(posedge clock);
		u_rem0.set(1'b0, 1'b0, 1'b0);
		pop(0, 8'h00, 5'h06);
		$display("stuck line test done");
		// transmit queue fills while the remote holds off
		flow_en[0] <= 1'b1;
		u_rem0.set(1'b1, 1'b0, 1'b0);
		repeat (4) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			push(0, 8'h11 * i[7:0]);
		end
		tx_valid[0] <= 1'b0;
		repeat (3) @(posedge clock);
		chk_bit(tx_ready[0], 1'b0);
		chk_bit(dma_tx_req[0], 1'b0);
		chk_bit(line_lvl[0], 1'b1);
		u_rem0.set(1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			u_rem0.get(1'b0, 1'b0, 1'b0, d, p, s);
			chk_val(d, 8'h11 * i[7:0]);
		end
		$display("transmit queue test done");
		// remote ignores the hold-off and overfills the receive queue
		receive_trigger_level[1] <= 4'h4;
		flow_en[1] <= 1'b1;
		u_rem1.set(1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 17; i++) begin
			u_rem1.send(i[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
			repeat (6) @(posedge clock);
			chk_bit(receive_level_flag[1], i >= 4);
			chk_bit(dma_rx_req[1], i >= 4);
			chk_bit(rts_n[1], i >= 13);
		end
		for (int i = 0; i < 16; i++) begin
			pop(1, i[7:0], 5'h00);
		end
		u_rem1.send(8'h77, 1'b0, 1'b0, 1'b0, 1'b0);
		pop(1, 8'h77, 5'h01 << ST_OVR);
		chk_bit(rts_n[1], 1'b0);
		u_rem1.set(1'b0, 1'b0, 1'b0);
		$display("receive queue test done");
		// pin source, and the generator at every prescale value and fed from the pin
		for (int i = 0; i < 6; i++) begin
			{clk_sel[1], brg_src_ext[1], prescale_sel[1], divisor[1], bitc[1]} <= rate[i];
			repeat (2) @(posedge clock);
			push(1, 8'h96 ^ i[7:0]);
			tx_valid[1] <= 1'b0;
			u_rem1.get(1'b0, 1'b0, 1'b0, d, p, s);
			chk_val(d, 8'h96 ^ i[7:0]);
			chk_bit(s, 1'b1);
		end
		$display("rate test done");
		finish_test();
	end
endmodule // testbench
`default_nettype wire
